/* File: rtl/gdp_pkg.sv */
// ==========================================
// shared constants of the gpio port
package gdp_pkg;
    localparam int PORT_WIDTH = 8; // pins in one port
    localparam int ADDR_WIDTH = 2; // register select width
    // register addresses within the port
    localparam logic [1:0] ADDR_INPUT_PINS = 2'h0;
    localparam logic [1:0] ADDR_DIRECTION = 2'h1;
    localparam logic [1:0] ADDR_OUTPUT_VALUE = 2'h2;
    // reset values
    localparam logic [7:0] RESET_DIRECTION = 8'h00;
    localparam logic [7:0] RESET_OUTPUT_VALUE = 8'h00;
    localparam logic [7:0] RESET_INPUT_PINS = 8'h00;
    // access commands
    typedef enum logic [1:0] {
        GDP_CMD_WRITE_BYTE,
        GDP_CMD_SET_BIT,
        GDP_CMD_CLEAR_BIT,
        GDP_CMD_NONE
    } gdp_cmd_type;
endpackage

/* File: rtl/gdp_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// input synchronizer: latch open while clock high, then flop
module gdp_pin_sync (
    input wire logic i_clock, // system clock
    input wire logic i_rst, // async reset
    input wire logic [7:0] i_pin, // pad levels after clamp
    output logic [7:0] o_sync // synchronized levels
);
    logic [7:0] sync_latch;

    // transparent while clock high, holds while low
    always_latch begin
        if (i_clock) begin
            sync_latch <= i_pin;
        end
    end

    // capture latch value on rising edge
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_sync <= gdp_pkg::RESET_INPUT_PINS;
        end else begin
            o_sync <= sync_latch;
        end
    end
endmodule // gdp_pin_sync
`default_nettype wire

/* File: rtl/gdp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module gdp_port (
    input wire logic I_CLOCK, // 125 MHz system clock
    input wire logic I_RST, // async reset, active high
    input wire logic [1:0] I_ADDR, // register select
    input wire logic I_WRITE, // write strobe, one cycle
    input wire logic [1:0] I_CMD, // byte write, bit set or bit clear
    input wire logic [2:0] I_BIT, // bit number for set or clear
    input wire logic [7:0] I_WDATA, // write data
    output logic [7:0] O_RDATA, // read data of selected register
    input wire logic I_GLOBAL_PULLUP_DISABLE, // disables all pull-ups
    input wire logic I_DEEP_SLEEP, // deep sleep clamp request
    input wire logic [7:0] I_EXT_INT_ENABLE, // pins kept live in sleep
    input wire logic [7:0] I_ALT_ENABLE, // pins owned by alternate function
    input wire logic [7:0] I_ALT_OE, // alternate output enable
    input wire logic [7:0] I_ALT_OUT, // alternate output value
    input wire logic [7:0] I_PIN, // pad input levels
    output logic [7:0] O_PIN, // pad output value
    output logic [7:0] O_PIN_OE, // pad drive enable
    output logic [7:0] O_PULLUP // pull-up enable per pin
);
    // ==========================================
    // registers and wires
    logic [7:0] port_direction;
    logic [7:0] port_output_value;
    logic [7:0] port_input_pins;
    logic [7:0] next_direction;
    logic [7:0] next_output_value;
    logic [7:0] pin_clamped;
    logic [7:0] pin_oe;
    logic [7:0] pin_out;
    logic [7:0] pin_pullup;
    logic [7:0] read_data;
    logic sel_direction;
    logic sel_output_value;
    logic sel_input_pins;
    gdp_pkg::gdp_cmd_type cmd;

    // ==========================================
    // register access
    // apply byte write, bit set or bit clear to one register
    function automatic logic [7:0] apply_write(
        input logic [7:0] cur,
        input gdp_pkg::gdp_cmd_type c,
        input logic [2:0] b,
        input logic [7:0] d
    );
        logic [7:0] r;
        r = cur;
        if (c == gdp_pkg::GDP_CMD_WRITE_BYTE) begin
            r = d;
        end else if (c == gdp_pkg::GDP_CMD_SET_BIT) begin
            r[b] = 1'b1;
        end else if (c == gdp_pkg::GDP_CMD_CLEAR_BIT) begin
            r[b] = 1'b0;
        end
        return r;
    endfunction

    // address decode, one select bit per register
    function automatic logic [2:0] decode_select(
        input logic [1:0] addr
    );
        logic [2:0] s;
        s = 3'h0;
        if (addr == gdp_pkg::ADDR_INPUT_PINS) begin
            s = 3'h1;
        end else if (addr == gdp_pkg::ADDR_DIRECTION) begin
            s = 3'h2;
        end else if (addr == gdp_pkg::ADDR_OUTPUT_VALUE) begin
            s = 3'h4;
        end
        return s;
    endfunction

    // select and write strobe wires
    logic [2:0] select;
    logic wr_direction;
    logic wr_output_value;

    // decoded command and register selects
    assign cmd = gdp_pkg::gdp_cmd_type'(I_CMD);
    assign select = decode_select(I_ADDR);
    assign sel_input_pins = select[0];
    assign sel_direction = select[1];
    assign sel_output_value = select[2];

    // write strobes; the input pins register has none
    assign wr_direction = I_WRITE & sel_direction;
    assign wr_output_value = I_WRITE & sel_output_value;

    // next register values
    assign next_direction = wr_direction ?
        apply_write(port_direction, cmd, I_BIT, I_WDATA) : port_direction;
    assign next_output_value = wr_output_value ?
        apply_write(port_output_value, cmd, I_BIT, I_WDATA) : port_output_value;

    // read mux; unmapped address reads zero
    function automatic logic [7:0] select_read(
        input logic [2:0] s,
        input logic [7:0] pins,
        input logic [7:0] dir,
        input logic [7:0] out
    );
        logic [7:0] v;
        v = 8'h00;
        if (s[0]) begin
            v = pins;
        end else if (s[1]) begin
            v = dir;
        end else if (s[2]) begin
            v = out;
        end
        return v;
    endfunction

    // read data of the addressed register
    assign read_data = select_read(select, port_input_pins, port_direction, port_output_value);

    // direction register, zero after reset
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            port_direction <= gdp_pkg::RESET_DIRECTION;
        end else begin
            port_direction <= next_direction;
        end
    end

    // output value register, zero after reset
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            port_output_value <= gdp_pkg::RESET_OUTPUT_VALUE;
        end else begin
            port_output_value <= next_output_value;
        end
    end

    // registered read data
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_RDATA <= 8'h00;
        end else begin
            O_RDATA <= read_data;
        end
    end

    // ==========================================
    // pin decode
    // {direction, output} to {drive enable, drive value, pull-up request}
    function automatic logic [2:0] decode_mode(
        input logic dir_bit,
        input logic out_bit
    );
        logic [2:0] m;
        m = 3'h0;
        case ({dir_bit, out_bit})
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h4;
            default: m = 3'h6;
        endcase
        return m;
    endfunction

    // per pin: an alternate function overrides only its own pin
    genvar gi;
    generate
        for (gi = 0; gi < gdp_pkg::PORT_WIDTH; gi++) begin : g_pin
            logic [2:0] mode;
            logic alt;
            assign mode = decode_mode(next_direction[gi], next_output_value[gi]);
            assign alt = I_ALT_ENABLE[gi];
            assign pin_oe[gi] = alt ? I_ALT_OE[gi] : mode[2];
            assign pin_out[gi] = alt ? I_ALT_OUT[gi] : mode[1];
            // no pull-up on alternate pins or under global disable
            assign pin_pullup[gi] = ~alt & mode[0] & ~I_GLOBAL_PULLUP_DISABLE;
        end
    endgenerate

    // pad outputs; reset tri-states without clock
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_PIN_OE <= 8'h00;
            O_PIN <= 8'h00;
            O_PULLUP <= 8'h00;
        end else begin
            O_PIN_OE <= pin_oe;
            O_PIN <= pin_out;
            O_PULLUP <= pin_pullup;
        end
    end

    // ==========================================
    // input path
    // clamp to ground in deep sleep except interrupt pins
    assign pin_clamped = I_PIN & ~({8{I_DEEP_SLEEP}} & ~I_EXT_INT_ENABLE);

    gdp_pin_sync u_sync (
        .i_clock(I_CLOCK),
        .i_rst(I_RST),
        .i_pin(pin_clamped),
        .o_sync(port_input_pins)
    );
endmodule // gdp_port
`default_nettype wire

/* File: dv/gdp_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// port checker
module gdp_port_monitor (
    input wire logic I_CLOCK, // clock
    input wire logic I_RST, // reset
    input wire logic [1:0] I_ADDR, // select
    input wire logic I_WRITE, // strobe
    input wire logic [1:0] I_CMD, // command
    input wire logic [2:0] I_BIT, // bit
    input wire logic [7:0] I_WDATA, // data
    input wire logic I_GLOBAL_PULLUP_DISABLE, // pull kill
    input wire logic [7:0] I_ALT_ENABLE, // alternate owners
    input wire logic [7:0] O_RDATA, // read
    input wire logic [7:0] O_PIN, // drive
    input wire logic [7:0] O_PIN_OE, // enable
    input wire logic [7:0] O_PULLUP // pull-up
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    // direction and output write strobes
    wire logic wd = I_WRITE && I_ADDR == 2'h1;
    wire logic wo = I_WRITE && I_ADDR == 2'h2;
    // no pin owned by an alternate function
    wire logic gp = I_ALT_ENABLE == 8'h00;
    a_dir_byte: assert property (gp && wd && I_CMD == 2'h0
        |=> O_PIN_OE == $past(I_WDATA)) else $error("dir byte");
    a_out_byte: assert property (gp && wo && I_CMD == 2'h0
        |=> ((O_PIN ^ $past(I_WDATA)) & O_PIN_OE) == 8'h00) else $error("out byte");
    a_dir_set: assert property (gp && $past(gp) && wd && I_CMD == 2'h1
        |=> O_PIN_OE == ($past(O_PIN_OE) | 8'h01 << $past(I_BIT))) else $error("set");
    a_dir_clear: assert property (gp && $past(gp) && wd && I_CMD == 2'h2
        |=> O_PIN_OE == ($past(O_PIN_OE) & ~(8'h01 << $past(I_BIT)))) else $error("clr");
    a_pins_ro: assert property (gp && $past(gp) && I_WRITE && I_ADDR == 2'h0
        |=> $stable(O_PIN_OE)) else $error("pins ro");
    a_no_pull_out: assert property ((O_PULLUP & O_PIN_OE) == 8'h00)
        else $error("pull on out");
    a_pull_off: assert property (I_GLOBAL_PULLUP_DISABLE [*2] |-> O_PULLUP == 8'h00)
        else $error("pull off");
    a_read_dir: assert property ($past(gp) && !I_WRITE && I_ADDR == 2'h1
        |=> O_RDATA == $past(O_PIN_OE)) else $error("read dir");
    c_set: cover property (wd && I_CMD == 2'h1);
    c_clear: cover property (wo && I_CMD == 2'h2);
    c_pull: cover property (O_PULLUP != 8'h00 ##1 I_GLOBAL_PULLUP_DISABLE);
endmodule // gdp_port_monitor
bind gdp_port gdp_port_monitor gdp_port_monitor_i (.*);
`default_nettype wire

/* File: dv/gdp_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// pads: port driver, board source, pull-up or float
module gdp_pad_model (
    input wire logic i_clock, // clock
    input wire logic [7:0] i_drv, // drive
    input wire logic [7:0] i_oe, // enable
    input wire logic [7:0] i_pu, // pull-up
    input wire logic [7:0] i_ext, // board level
    input wire logic [7:0] i_ext_en, // board drives
    output logic [7:0] o_level // pad level
);
    logic [7:0] flt = 8'h5A;
    // undriven pad wanders every cycle
    always @(posedge i_clock) flt <= #2 ~flt;
    // port driver wins, then board, then pull-up
    assign o_level = i_oe & i_drv | ~i_oe & (i_ext_en & i_ext | ~i_ext_en & (i_pu | flt));
endmodule // gdp_pad_model
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// random register traffic against the pad model
module tb;
    logic I_CLOCK = 0, I_RST = 1, I_WRITE = 0, I_GLOBAL_PULLUP_DISABLE = 0, I_DEEP_SLEEP = 0;
    logic [1:0] I_ADDR = '0, I_CMD = '0;
    logic [2:0] I_BIT = '0;
    logic [7:0] I_WDATA = '0, I_EXT_INT_ENABLE = '0, I_ALT_ENABLE = '0, I_ALT_OE = '0;
    logic [7:0] I_ALT_OUT = '0, ext = '0, ext_en = '0, dir = '0, outv = '0, rd;
    logic [31:0] r, q;
    wire logic [7:0] O_RDATA, O_PIN, O_PIN_OE, O_PULLUP, I_PIN;
    int fails = 0, compares = 0, seed = 76187, cyc = 0;
    gdp_port gdp_port_i (.*);
    gdp_pad_model gdp_pad_model_i (.i_clock(I_CLOCK), .i_drv(O_PIN), .i_oe(O_PIN_OE),
        .i_pu(O_PULLUP), .i_ext(ext), .i_ext_en(ext_en), .o_level(I_PIN));
    // clock and hang guard
    always #4 I_CLOCK = ~I_CLOCK;
    always @(posedge I_CLOCK) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            results();
        end
    end
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one access, read data sampled after its edge
    task automatic acc(input logic [1:0] a, c, input logic [2:0] b, input logic [7:0] d, w);
        {I_ADDR, I_CMD, I_BIT, I_WDATA, I_WRITE} = {a, c, b, d, w[0]};
        @(posedge I_CLOCK) #1;
        rd = O_RDATA;
    endtask
    function automatic logic [7:0] upd(input logic [7:0] v, d, input logic [1:0] c, input logic [2:0] b);
        case (c)
            2'h0: return d;
            2'h1: return v | 8'h01 << b;
            2'h2: return v & ~(8'h01 << b);
            default: return v;
        endcase
    endfunction
    // access, check pads, two idle cycles, read pins back
    task automatic step(input logic [1:0] a, c, input logic [2:0] b, input logic [7:0] d, w);
        logic [7:0] er, pu, m, oe, ov, cl, ep;
        er = a == 2'h1 ? dir : a == 2'h2 ? outv : 8'h00;
        acc(a, c, b, d, w);
        if (a != 2'h0) chk(rd, er);
        if (w[0] && a == 2'h1) dir = upd(dir, d, c, b);
        if (w[0] && a == 2'h2) outv = upd(outv, d, c, b);
        // alternate pins follow their override, the rest stay gpio
        oe = I_ALT_ENABLE & I_ALT_OE | ~I_ALT_ENABLE & dir;
        ov = I_ALT_ENABLE & I_ALT_OUT | ~I_ALT_ENABLE & outv;
        pu = ~I_ALT_ENABLE & ~dir & outv & {8{~I_GLOBAL_PULLUP_DISABLE}};
        cl = {8{I_DEEP_SLEEP}} & ~I_EXT_INT_ENABLE;
        chk(O_PIN_OE, oe);
        chk(O_PIN & oe, ov & oe);
        chk(O_PULLUP, pu);
        m = oe | ext_en | pu | cl;
        ep = (oe & ov | ~oe & (ext_en & ext | ~ext_en & pu)) & ~cl;
        acc(2'h0, 2'h3, 3'h0, 8'h00, 8'h00);
        acc(2'h0, 2'h3, 3'h0, 8'h00, 8'h00);
        chk(rd & m, ep & m);
    endtask
    // corners, random traffic, reset in mid-run
    initial begin
        repeat (12) @(posedge I_CLOCK);
        #1 I_RST = 0;
        step(2'h1, 2'h1, 3'h7, 8'h00, 8'h01);
        step(2'h2, 2'h2, 3'h0, 8'h00, 8'h01);
        step(2'h0, 2'h0, 3'h0, 8'hFF, 8'h01);
        step(2'h3, 2'h0, 3'h0, 8'hFF, 8'h01);
        repeat (300) begin
            r = $random(seed);
            {ext, ext_en} = r[31:16];
            I_GLOBAL_PULLUP_DISABLE = r[7] & r[8];
            q = $random(seed);
            I_ALT_ENABLE = q[7:0] & {8{q[26] & q[27]}};
            {I_ALT_OE, I_ALT_OUT} = q[23:8];
            I_EXT_INT_ENABLE = q[31:24];
            I_DEEP_SLEEP = q[28] & q[29];
            // one register per write: each pin moves one config bit at a time
            step(r[1:0], r[3:2], r[6:4], r[14:7], {7'h00, r[15]});
        end
        step(2'h1, 2'h0, 3'h0, 8'hFF, 8'h01);
        I_RST = 1;
        #1 chk(O_PIN_OE | O_PULLUP, 8'h00);
        @(posedge I_CLOCK) #1 I_RST = 0;
        dir = 8'h00;
        outv = 8'h00;
        step(2'h1, 2'h3, 3'h0, 8'h00, 8'h00);
        results();
    end
endmodule // tb
`default_nettype wire
